// ### src/ppfs_defines.vh
// constants for the port pin function select block
`ifndef PPFS_DEFINES_VH
`define PPFS_DEFINES_VH

// ****************************************************************
// bus geometry
// ****************************************************************
`define PPFS_AXI_AW        18
`define PPFS_IDX_W         16
`define PPFS_LO_W          8
`define PPFS_UP_W          4
`define PPFS_SYNC_W        12

// ****************************************************************
// register indexes, byte address is four times the index
// ****************************************************************
`define PPFS_IDX_FSEL_LO   16'hffb5
`define PPFS_IDX_FSEL_GL   16'hffb6
`define PPFS_IDX_DIR_LO    16'hffc0
`define PPFS_IDX_ADCFG     16'hffc1
`define PPFS_IDX_LATCH_LO  16'hffc2
`define PPFS_IDX_DIR_UP    16'hffc3
`define PPFS_IDX_PULLUP    16'hffc4
`define PPFS_IDX_LATCH_UP  16'hffc5
`define PPFS_IDX_PIN_LO    16'hffc6
`define PPFS_IDX_PIN_UP    16'hffc7

// ****************************************************************
// reset values
// ****************************************************************
`define PPFS_RST_FSEL      8'h00
`define PPFS_RST_ADCFG     8'h00
`define PPFS_RST_DIR_LO    8'hff
`define PPFS_RST_DIR_UP    4'hf
`define PPFS_RST_PULLUP    4'h0
`define PPFS_RST_LATCH_LO  8'h00
`define PPFS_RST_LATCH_UP  4'h0

// ****************************************************************
// bus responses and select codes
// ****************************************************************
`define PPFS_RESP_OKAY     2'b00
`define PPFS_RESP_SLVERR   2'b10
`define PPFS_SEL_W         10
`define PPFS_SEL_NONE      10'h000
`define PPFS_SEL_FSEL_LO   0
`define PPFS_SEL_FSEL_GL   1
`define PPFS_SEL_DIR_LO    2
`define PPFS_SEL_ADCFG     3
`define PPFS_SEL_LATCH_LO  4
`define PPFS_SEL_DIR_UP    5
`define PPFS_SEL_PULLUP    6
`define PPFS_SEL_LATCH_UP  7
`define PPFS_SEL_PIN_LO    8
`define PPFS_SEL_PIN_UP    9

`endif

// ### src/ppfs_pin_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`include "ppfs_defines.vh"
module ppfs_pin_sync #(
  parameter W = `PPFS_SYNC_W
) (
  // clock and reset
  input  wire         core_clk,
  input  wire         rst_n,
  // pins in and filtered level out
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_q
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  // ****************************************************************
  // stage chain, a level counts once stages two and three agree
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge core_clk) begin
        if (!rst_n) begin
          s1_r[g]  <= 1'b0;
          s2_r[g]  <= 1'b0;
          s3_r[g]  <= 1'b0;
          pin_q[g] <= 1'b0;
        end else begin
          s1_r[g] <= pin_in[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g]) begin
            pin_q[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate

endmodule // ppfs_pin_sync

// ### src/ppfs_port_fsel.v
// port pin function select with axi4-lite register access
//
// Operation
// - eight-pin port, direction per pin
// - eight-pin port: gpio, analog input or lcd segment
// - segments map in reverse pin order
// - reset leaves eight pins analog inputs
// - four-pin port, direction per pin
// - per-pin pull-up on four-pin port
// - control mode routes pins to peripherals
// - direction zero drives, one releases pin
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`include "ppfs_defines.vh"
module ppfs_port_fsel (
  // clock and reset
  input  wire                     core_clk,
  input  wire                     rst_n,
  // axi4-lite write address
  input  wire [`PPFS_AXI_AW-1:0]  s_axi_awaddr,
  input  wire [2:0]               s_axi_awprot,
  input  wire                     s_axi_awvalid,
  output reg                      s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]              s_axi_wdata,
  input  wire [3:0]               s_axi_wstrb,
  input  wire                     s_axi_wvalid,
  output reg                      s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]               s_axi_bresp,
  output reg                      s_axi_bvalid,
  input  wire                     s_axi_bready,
  // axi4-lite read address
  input  wire [`PPFS_AXI_AW-1:0]  s_axi_araddr,
  input  wire [2:0]               s_axi_arprot,
  input  wire                     s_axi_arvalid,
  output reg                      s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]              s_axi_rdata,
  output reg  [1:0]               s_axi_rresp,
  output reg                      s_axi_rvalid,
  input  wire                     s_axi_rready,
  // eight-pin port
  input  wire [`PPFS_LO_W-1:0]    lower_port_pins_in,
  output reg  [`PPFS_LO_W-1:0]    lower_port_pins_out,
  output reg  [`PPFS_LO_W-1:0]    lower_port_pins_oe,
  output reg  [`PPFS_LO_W-1:0]    sar_converter_inputs_en,
  // lcd segments, index 0 is the lowest segment number
  input  wire [`PPFS_LO_W-1:0]    lcd_segment_outputs,
  // four-pin port
  input  wire [`PPFS_UP_W-1:0]    upper_port_pins_in,
  output reg  [`PPFS_UP_W-1:0]    upper_port_pins_out,
  output reg  [`PPFS_UP_W-1:0]    upper_port_pins_oe,
  output reg  [`PPFS_UP_W-1:0]    upper_port_pullup_enable,
  // alternate-function peripherals on the four-pin port
  input  wire [`PPFS_UP_W-1:0]    upper_alt_out,
  input  wire [`PPFS_UP_W-1:0]    upper_alt_oe,
  output reg  [`PPFS_UP_W-1:0]    upper_alt_in
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  function [`PPFS_SEL_W-1:0] ppfs_decode;
    input [`PPFS_AXI_AW-1:0] addr;
    reg   [`PPFS_IDX_W-1:0]  idx;
    begin
      idx = addr[`PPFS_AXI_AW-1:2];
      ppfs_decode = `PPFS_SEL_NONE;
      if (addr[1:0] == 2'b00) begin
        case (idx)
          `PPFS_IDX_FSEL_LO:  ppfs_decode[`PPFS_SEL_FSEL_LO]  = 1'b1;
          `PPFS_IDX_FSEL_GL:  ppfs_decode[`PPFS_SEL_FSEL_GL]  = 1'b1;
          `PPFS_IDX_DIR_LO:   ppfs_decode[`PPFS_SEL_DIR_LO]   = 1'b1;
          `PPFS_IDX_ADCFG:    ppfs_decode[`PPFS_SEL_ADCFG]    = 1'b1;
          `PPFS_IDX_LATCH_LO: ppfs_decode[`PPFS_SEL_LATCH_LO] = 1'b1;
          `PPFS_IDX_DIR_UP:   ppfs_decode[`PPFS_SEL_DIR_UP]   = 1'b1;
          `PPFS_IDX_PULLUP:   ppfs_decode[`PPFS_SEL_PULLUP]   = 1'b1;
          `PPFS_IDX_LATCH_UP: ppfs_decode[`PPFS_SEL_LATCH_UP] = 1'b1;
          `PPFS_IDX_PIN_LO:   ppfs_decode[`PPFS_SEL_PIN_LO]   = 1'b1;
          `PPFS_IDX_PIN_UP:   ppfs_decode[`PPFS_SEL_PIN_UP]   = 1'b1;
          default:            ppfs_decode = `PPFS_SEL_NONE;
        endcase
      end
    end
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  reg  [`PPFS_AXI_AW-1:0]  awaddr_r;
  reg                      aw_have_r;
  reg  [31:0]              wdata_r;
  reg  [3:0]               wstrb_r;
  reg                      w_have_r;
  reg  [`PPFS_LO_W-1:0]    fsel_lo_r;
  reg  [`PPFS_LO_W-1:0]    fsel_gl_r;
  reg  [`PPFS_LO_W-1:0]    dir_lo_r;
  reg  [`PPFS_LO_W-1:0]    adcfg_r;
  reg  [`PPFS_LO_W-1:0]    latch_lo_r;
  reg  [`PPFS_UP_W-1:0]    dir_up_r;
  reg  [`PPFS_UP_W-1:0]    pullup_r;
  reg  [`PPFS_UP_W-1:0]    latch_up_r;
  wire [`PPFS_SYNC_W-1:0]  pins_q;
  wire [`PPFS_LO_W-1:0]    pin_lo_q;
  wire [`PPFS_UP_W-1:0]    pin_up_q;
  wire [`PPFS_UP_W-1:0]    ctrl_up;
  wire [`PPFS_SEL_W-1:0]   wsel;
  wire [`PPFS_SEL_W-1:0]   rsel;
  wire                     wr_go;
  wire                     wr_en;
  reg  [31:0]              rd_mux;
  reg  [`PPFS_LO_W-1:0]    lo_out_nxt;
  reg  [`PPFS_LO_W-1:0]    lo_oe_nxt;
  reg  [`PPFS_LO_W-1:0]    lo_ana_nxt;
  reg  [`PPFS_UP_W-1:0]    up_out_nxt;
  reg  [`PPFS_UP_W-1:0]    up_oe_nxt;
  integer                  i;
  integer                  j;

  assign pin_lo_q = pins_q[`PPFS_LO_W-1:0];
  assign pin_up_q = pins_q[`PPFS_SYNC_W-1:`PPFS_LO_W];
  // low nibble of the global select puts each upper pin in control mode
  assign ctrl_up  = fsel_gl_r[`PPFS_UP_W-1:0];
  assign wsel     = ppfs_decode(awaddr_r);
  assign rsel     = ppfs_decode(s_axi_araddr);
  assign wr_go    = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wr_en    = wr_go & wstrb_r[0];

  // ****************************************************************
  // pin input synchroniser
  // ****************************************************************
  ppfs_pin_sync #(
    .W (`PPFS_SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   ({upper_port_pins_in, lower_port_pins_in}),
    .pin_q    (pins_q)
  );

  // ****************************************************************
  // write channel: address and data taken in either order
  // ****************************************************************
  always @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PPFS_RESP_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= {`PPFS_AXI_AW{1'b0}};
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r      <= s_axi_awaddr;
        aw_have_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        w_have_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == `PPFS_SEL_NONE) ? `PPFS_RESP_SLVERR
                                                 : `PPFS_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // register file, only byte lane 0 carries data
  // ****************************************************************
  always @(posedge core_clk) begin
    if (!rst_n) begin
      fsel_lo_r  <= `PPFS_RST_FSEL;
      fsel_gl_r  <= `PPFS_RST_FSEL;
      adcfg_r    <= `PPFS_RST_ADCFG;
      dir_lo_r   <= `PPFS_RST_DIR_LO;
      latch_lo_r <= `PPFS_RST_LATCH_LO;
      dir_up_r   <= `PPFS_RST_DIR_UP;
      pullup_r   <= `PPFS_RST_PULLUP;
      latch_up_r <= `PPFS_RST_LATCH_UP;
    end else if (wr_en) begin
      if (wsel[`PPFS_SEL_FSEL_LO]) begin
        fsel_lo_r <= wdata_r[`PPFS_LO_W-1:0];
      end
      if (wsel[`PPFS_SEL_FSEL_GL]) begin
        fsel_gl_r <= wdata_r[`PPFS_LO_W-1:0];
      end
      if (wsel[`PPFS_SEL_DIR_LO]) begin
        dir_lo_r <= wdata_r[`PPFS_LO_W-1:0];
      end
      if (wsel[`PPFS_SEL_ADCFG]) begin
        adcfg_r <= wdata_r[`PPFS_LO_W-1:0];
      end
      if (wsel[`PPFS_SEL_LATCH_LO]) begin
        latch_lo_r <= wdata_r[`PPFS_LO_W-1:0];
      end
      if (wsel[`PPFS_SEL_DIR_UP]) begin
        dir_up_r <= wdata_r[`PPFS_UP_W-1:0];
      end
      if (wsel[`PPFS_SEL_PULLUP]) begin
        pullup_r <= wdata_r[`PPFS_UP_W-1:0];
      end
      if (wsel[`PPFS_SEL_LATCH_UP]) begin
        latch_up_r <= wdata_r[`PPFS_UP_W-1:0];
      end
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  always @* begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      rsel[`PPFS_SEL_FSEL_LO]:  rd_mux[`PPFS_LO_W-1:0] = fsel_lo_r;
      rsel[`PPFS_SEL_FSEL_GL]:  rd_mux[`PPFS_LO_W-1:0] = fsel_gl_r;
      rsel[`PPFS_SEL_DIR_LO]:   rd_mux[`PPFS_LO_W-1:0] = dir_lo_r;
      rsel[`PPFS_SEL_ADCFG]:    rd_mux[`PPFS_LO_W-1:0] = adcfg_r;
      rsel[`PPFS_SEL_LATCH_LO]: rd_mux[`PPFS_LO_W-1:0] = latch_lo_r;
      rsel[`PPFS_SEL_DIR_UP]:   rd_mux[`PPFS_UP_W-1:0] = dir_up_r;
      rsel[`PPFS_SEL_PULLUP]:   rd_mux[`PPFS_UP_W-1:0] = pullup_r;
      rsel[`PPFS_SEL_LATCH_UP]: rd_mux[`PPFS_UP_W-1:0] = latch_up_r;
      rsel[`PPFS_SEL_PIN_LO]:   rd_mux[`PPFS_LO_W-1:0] = pin_lo_q;
      rsel[`PPFS_SEL_PIN_UP]:   rd_mux[`PPFS_UP_W-1:0] = pin_up_q;
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PPFS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= (rsel == `PPFS_SEL_NONE) ? `PPFS_RESP_SLVERR
                                                  : `PPFS_RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // eight-pin port function mux
  // ****************************************************************
  always @* begin
    lo_out_nxt = {`PPFS_LO_W{1'b0}};
    lo_oe_nxt  = {`PPFS_LO_W{1'b0}};
    lo_ana_nxt = {`PPFS_LO_W{1'b0}};
    for (i = 0; i < `PPFS_LO_W; i = i + 1) begin
      if (fsel_lo_r[i]) begin
        // segment output: lowest pin carries highest segment
        lo_out_nxt[i] = lcd_segment_outputs[`PPFS_LO_W-1-i];
        lo_oe_nxt[i]  = 1'b1;
      end else if (!adcfg_r[i]) begin
        // analog input, digital buffer off
        lo_ana_nxt[i] = 1'b1;
      end else begin
        lo_out_nxt[i] = latch_lo_r[i];
        lo_oe_nxt[i]  = ~dir_lo_r[i];
      end
    end
  end

  // ****************************************************************
  // four-pin port function mux
  // ****************************************************************
  always @* begin
    up_out_nxt = {`PPFS_UP_W{1'b0}};
    up_oe_nxt  = {`PPFS_UP_W{1'b0}};
    for (j = 0; j < `PPFS_UP_W; j = j + 1) begin
      if (ctrl_up[j]) begin
        up_out_nxt[j] = upper_alt_out[j];
        up_oe_nxt[j]  = upper_alt_oe[j];
      end else begin
        up_out_nxt[j] = latch_up_r[j];
        up_oe_nxt[j]  = ~dir_up_r[j];
      end
    end
  end

  // ****************************************************************
  // registered pin outputs
  // ****************************************************************
  always @(posedge core_clk) begin
    if (!rst_n) begin
      lower_port_pins_out      <= {`PPFS_LO_W{1'b0}};
      lower_port_pins_oe       <= {`PPFS_LO_W{1'b0}};
      sar_converter_inputs_en  <= {`PPFS_LO_W{1'b1}};
      upper_port_pins_out      <= {`PPFS_UP_W{1'b0}};
      upper_port_pins_oe       <= {`PPFS_UP_W{1'b0}};
      upper_port_pullup_enable <= {`PPFS_UP_W{1'b0}};
      upper_alt_in             <= {`PPFS_UP_W{1'b0}};
    end else begin
      lower_port_pins_out      <= lo_out_nxt;
      lower_port_pins_oe       <= lo_oe_nxt;
      sar_converter_inputs_en  <= lo_ana_nxt;
      upper_port_pins_out      <= up_out_nxt;
      upper_port_pins_oe       <= up_oe_nxt;
      // pull-up only while the pin is not driven
      upper_port_pullup_enable <= pullup_r & ~up_oe_nxt;
      upper_alt_in             <= pin_up_q & ctrl_up;
    end
  end

endmodule // ppfs_port_fsel

// ### sim/ppfs_pin_model.sv
// far-side model: pin levels seen by both ports
`timescale 1ns/100ps
module ppfs_pin_model (
  // design drive
  input  logic [7:0] lo_out,
  input  logic [7:0] lo_oe,
  input  logic [3:0] up_out,
  input  logic [3:0] up_oe,
  input  logic [3:0] up_pu,
  // outside drivers
  input  logic [7:0] lo_ext,
  input  logic [3:0] up_ext,
  // resolved pins
  output logic [7:0] lo_pin,
  output logic [3:0] up_pin
);
  // a driven pin shows the design level, else the outside one
  assign lo_pin = (lo_oe & lo_out) | (~lo_oe & lo_ext);
  // pull-up wins over an open outside line
  assign up_pin = (up_oe & up_out) | (~up_oe & (up_pu | up_ext));
endmodule // ppfs_pin_model

// ### sim/ppfs_port_fsel_monitor.sv
// port-level assertions for the port function select block
`timescale 1ns/100ps
`include "ppfs_defines.vh"
module ppfs_port_fsel_monitor (
  // clock and reset
  input logic                  core_clk,
  input logic                  rst_n,
  // bus handshakes
  input logic                  s_axi_awvalid,
  input logic                  s_axi_awready,
  input logic                  s_axi_wvalid,
  input logic                  s_axi_wready,
  input logic                  s_axi_bvalid,
  input logic                  s_axi_arvalid,
  input logic                  s_axi_arready,
  input logic                  s_axi_rvalid,
  input logic                  s_axi_rready,
  // pins
  input logic [`PPFS_LO_W-1:0] sar_converter_inputs_en,
  input logic [`PPFS_LO_W-1:0] lower_port_pins_oe,
  input logic [`PPFS_UP_W-1:0] upper_port_pins_oe,
  input logic [`PPFS_UP_W-1:0] upper_port_pullup_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ********
  // sequences
  // ********
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ********
  // properties
  // ********
  property p_rst_state;
    $rose(rst_n) |-> sar_converter_inputs_en == 8'hff &&
      lower_port_pins_oe == 8'h00 && upper_port_pins_oe == 4'h0;
  endproperty
  property p_lo_excl;
    (sar_converter_inputs_en & lower_port_pins_oe) == 8'h00;
  endproperty
  property p_pullup;
    (upper_port_pullup_enable & upper_port_pins_oe) == 4'h0;
  endproperty
  property p_wr_resp;
    s_wr_take |-> ##2 s_axi_bvalid;
  endproperty
  property p_ar_resp;
    s_ar_take |=> s_axi_rvalid;
  endproperty
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_r_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_r_clear;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_rst_state: assert property (p_rst_state)
    else $error("pins not analog after reset");
  a_lo_excl: assert property (p_lo_excl)
    else $error("lower pin driven in analog mode");
  a_pullup: assert property (p_pullup)
    else $error("pull-up on a driven pin");
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response late");
  a_ar_resp: assert property (p_ar_resp)
    else $error("read response late");
  a_w_block: assert property (p_w_block)
    else $error("write taken while response pending");
  a_r_block: assert property (p_r_block)
    else $error("read taken while data pending");
  a_r_clear: assert property (p_r_clear)
    else $error("read channel not released");
endmodule // ppfs_port_fsel_monitor

bind ppfs_port_fsel ppfs_port_fsel_monitor ppfs_port_fsel_monitor_inst (
  .core_clk(core_clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .sar_converter_inputs_en(sar_converter_inputs_en),
  .lower_port_pins_oe(lower_port_pins_oe),
  .upper_port_pins_oe(upper_port_pins_oe),
  .upper_port_pullup_enable(upper_port_pullup_enable)
);

// ### sim/ppfs_port_fsel_tb.sv
// self-checking bench for the port function select block
`timescale 1ns/100ps
`include "ppfs_defines.vh"
module ppfs_port_fsel_tb;
  localparam logic [1:0] OK = `PPFS_RESP_OKAY;
  localparam logic [1:0] SE = `PPFS_RESP_SLVERR;
  localparam logic [17:0] A_FLO = {`PPFS_IDX_FSEL_LO, 2'b00};
  localparam logic [17:0] A_FGL = {`PPFS_IDX_FSEL_GL, 2'b00};
  localparam logic [17:0] A_DLO = {`PPFS_IDX_DIR_LO, 2'b00};
  localparam logic [17:0] A_ADC = {`PPFS_IDX_ADCFG, 2'b00};
  localparam logic [17:0] A_LLO = {`PPFS_IDX_LATCH_LO, 2'b00};
  localparam logic [17:0] A_DUP = {`PPFS_IDX_DIR_UP, 2'b00};
  localparam logic [17:0] A_PU = {`PPFS_IDX_PULLUP, 2'b00};
  localparam logic [17:0] A_LUP = {`PPFS_IDX_LATCH_UP, 2'b00};
  localparam logic [17:0] A_PLO = {`PPFS_IDX_PIN_LO, 2'b00};
  localparam logic [17:0] A_PUP = {`PPFS_IDX_PIN_UP, 2'b00};
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [17:0] aw_a = 18'h0_0000, ar_a = 18'h0_0000;
  logic [31:0] w_d = 32'h0000_0000, r_d;
  logic [3:0]  w_s = 4'h0;
  logic        aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0;
  logic        ar_v = 1'b0, r_rdy = 1'b0;
  logic        aw_r, w_r, b_v, ar_r, r_v;
  logic [1:0]  b_resp, r_resp;
  logic [7:0]  lo_out, lo_oe, ana_en, lo_pin, lcd = 8'h00, lo_ext = 8'h00;
  logic [3:0]  up_out, up_oe, up_pu, up_pin, alt_in;
  logic [3:0]  alt_out = 4'h0, alt_oe = 4'h0, up_ext = 4'h0;
  int          errors = 0, total_checks = 0;

  always #2 core_clk = ~core_clk;

  ppfs_port_fsel ppfs_port_fsel_inst (
    .core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awaddr(aw_a), .s_axi_awprot(3'b000), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(w_s),
    .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_resp),
    .s_axi_bvalid(b_v), .s_axi_bready(b_rdy), .s_axi_araddr(ar_a),
    .s_axi_arprot(3'b000), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
    .s_axi_rready(r_rdy), .lower_port_pins_in(lo_pin),
    .lower_port_pins_out(lo_out), .lower_port_pins_oe(lo_oe),
    .sar_converter_inputs_en(ana_en), .lcd_segment_outputs(lcd),
    .upper_port_pins_in(up_pin), .upper_port_pins_out(up_out),
    .upper_port_pins_oe(up_oe), .upper_port_pullup_enable(up_pu),
    .upper_alt_out(alt_out), .upper_alt_oe(alt_oe), .upper_alt_in(alt_in)
  );

  ppfs_pin_model ppfs_pin_model_inst (
    .lo_out(lo_out), .lo_oe(lo_oe), .up_out(up_out), .up_oe(up_oe),
    .up_pu(up_pu), .lo_ext(lo_ext), .up_ext(up_ext),
    .lo_pin(lo_pin), .up_pin(up_pin)
  );

  // ********
  // shared tasks
  // ********
  task end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tmo(input int n);
    if (n >= 50) begin
      chk(32'h0, 32'h1);
      end_sim;
    end
  endtask

  task st(input int c);
    repeat (c) @(posedge core_clk);
  endtask

  task wr(input logic [17:0] a, input logic [31:0] d,
          input logic [3:0] s, input logic [1:0] er);
    int n;
    aw_a <= a;
    w_d <= d;
    w_s <= s;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_rdy <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (aw_v && aw_r) aw_v <= 1'b0;
      if (w_v && w_r) w_v <= 1'b0;
      if (b_v === 1'b1) break;
    end
    b_rdy <= 1'b0;
    tmo(n);
    chk({30'h0, b_resp}, {30'h0, er});
    @(posedge core_clk);
  endtask

  task rd(input logic [17:0] a, input logic [31:0] ed,
          input logic [1:0] er);
    int n;
    ar_a <= a;
    ar_v <= 1'b1;
    r_rdy <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (ar_v && ar_r) ar_v <= 1'b0;
      if (r_v === 1'b1) break;
    end
    r_rdy <= 1'b0;
    tmo(n);
    chk(r_d, ed);
    chk({30'h0, r_resp}, {30'h0, er});
    @(posedge core_clk);
  endtask

  // ********
  // scenarios
  // ********
  task t_reset;
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'hff, 8'h00,
                           8'h00, 8'h0f, 8'h00, 8'h00};
    logic [15:0] idx;
    chk(ana_en, 8'hff);
    chk({lo_oe, up_oe, up_pu}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      idx = (i < 2) ? `PPFS_IDX_FSEL_LO + i : `PPFS_IDX_DIR_LO + i - 2;
      rd({idx, 2'b00}, {24'h0, rv[i]}, OK);
    end
  endtask

  task t_lower;
    lo_ext <= 8'h3c;
    wr(A_ADC, 32'h01, 4'hf, OK);
    wr(A_LLO, 32'ha5, 4'hf, OK);
    wr(A_DLO, 32'hfe, 4'hf, OK);
    chk(lo_oe, 8'h01);
    chk(lo_out & lo_oe, 8'h01);
    chk(ana_en, 8'hfe);
    wr(A_ADC, 32'hff, 4'hf, OK);
    wr(A_LLO, 32'h5a, 4'hf, OK);
    wr(A_DLO, 32'h0f, 4'hf, OK);
    chk(lo_oe, 8'hf0);
    chk(lo_out & lo_oe, 8'h50);
    chk(ana_en, 8'h00);
    st(6);
    rd(A_PLO, 32'h5c, OK);
  endtask

  task t_seg;
    lcd <= 8'h0b;
    wr(A_FLO, 32'hff, 4'hf, OK);
    chk(lo_oe, 8'hff);
    chk(lo_out, 8'hd0);
    wr(A_FLO, 32'h0f, 4'hf, OK);
    chk(lo_out, 8'h50);
    rd(A_FLO, 32'h0f, OK);
  endtask

  task t_up;
    wr(A_PU, 32'hf, 4'hf, OK);
    wr(A_LUP, 32'h3, 4'hf, OK);
    wr(A_DUP, 32'hc, 4'hf, OK);
    chk(up_oe, 4'h3);
    chk(up_out & up_oe, 4'h3);
    chk(up_pu, 4'hc);
    st(6);
    rd(A_PUP, 32'hf, OK);
  endtask

  task t_ctrl;
    alt_out <= 4'he;
    alt_oe <= 4'h1;
    up_ext <= 4'h4;
    wr(A_PU, 32'h8, 4'hf, OK);
    wr(A_FGL, 32'hf5, 4'hf, OK);
    chk(up_oe, 4'h3);
    chk(up_out & up_oe, 4'h2);
    chk(up_pu, 4'h8);
    st(6);
    chk(alt_in, 4'h4);
    rd(A_FGL, 32'hf5, OK);
  endtask

  task t_err;
    rd(18'h0_0000, 32'h0, SE);
    rd(A_FLO + 18'h1, 32'h0, SE);
    wr(18'h0_0000, 32'h1, 4'hf, SE);
    wr(A_PLO, 32'hff, 4'hf, OK);
    wr(A_LUP, 32'h0, 4'h0, OK);
    rd(A_LUP, 32'h3, OK);
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_reset;
    t_lower;
    t_seg;
    t_up;
    t_ctrl;
    t_err;
    end_sim;
  end
endmodule // ppfs_port_fsel_tb
